// [common/pcw_pkg.sv]
// Constants shared by the clock control block and its glitch-free clock switch.
// Assumes a byte-addressed AXI4-Lite register port with 32-bit data.
package pcw_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 4'h4;

  // Control word fields
  localparam int SYS_SEL_BIT = 0;
  localparam int STOP_VCO_BIT = 1;
  localparam int STOP_XTAL_BIT = 2;
  localparam int OUT_SEL_LSB = 3;
  localparam int WAKE_SRC_LSB = 5;
  localparam int WAKE_POL_BIT = 7;
  localparam int DIV_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0100;

  // Status word fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_ON_PLL_BIT = 4;
  localparam int STAT_ON_PIN_BIT = 5;
  localparam int STAT_MULT_LSB = 16;

  localparam int VCO_MULT = 4;
  localparam int MULT_W = 10;
  localparam logic [MULT_W-1:0] XTAL_X2_MULT = 10'h002;
  localparam int WAKE_SRCS = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    PCW_OUT_VCO = 2'b00,
    PCW_OUT_VCO_DIV2 = 2'b01,
    PCW_OUT_VCO_DIV4 = 2'b10,
    PCW_OUT_XTAL_X2 = 2'b11
  } pcw_out_sel_t;

  typedef enum logic [2:0]
  {
    PCW_MODE_DEFAULT = 3'b000,
    PCW_MODE_PLL = 3'b001,
    PCW_MODE_XTAL_DIRECT = 3'b010,
    PCW_MODE_EXT_DIRECT = 3'b011,
    PCW_MODE_DEEP_SLEEP = 3'b100,
    PCW_MODE_OTHER = 3'b111
  } pcw_mode_t;

  typedef enum logic [0:0]
  {
    PCW_ST_RUN = 1'b0,
    PCW_ST_SLEEP = 1'b1
  } pcw_state_t;
endpackage

// [src/pcw_clk_switch.sv]
// Glitch-free selector between the clock input pin level and the PLL output level.
// Assumes both levels are synchronous to aclk and toggle no faster than aclk/2.
`timescale 1ns/1ns
module pcw_clk_switch
  import pcw_pkg::*;
(
  input wire logic aclk, // Block clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic pin_level, // Clock input pin level
  input wire logic pll_level, // PLL output level
  input wire logic want_pll, // Request the PLL source
  input wire logic run, // Low halts the system clock
  output logic sys_clk, // Switched system clock level
  output logic on_pin, // Pin source is connected
  output logic on_pll // PLL source is connected
);
  import pcw_pkg::*;

  typedef struct packed
  {
    logic sel_pin;
    logic sel_pll;
    logic clk;
  } pcw_sw_t;

  pcw_sw_t s_reg;
  pcw_sw_t s_next;

  always_comb
  begin
    logic want_pin_l;
    logic want_pll_l;
    want_pin_l = run && !want_pll;
    want_pll_l = run && want_pll;
    s_next = s_reg;
    // A source is only connected or cut while its level is low, so no pulse is shortened
    if (s_reg.sel_pin && !want_pin_l && !pin_level)
      s_next.sel_pin = 1'b0;
    if (s_reg.sel_pll && !want_pll_l && !pll_level)
      s_next.sel_pll = 1'b0;
    if (want_pin_l && !s_reg.sel_pll && !s_reg.sel_pin && !pin_level)
      s_next.sel_pin = 1'b1;
    if (want_pll_l && !s_reg.sel_pin && !s_reg.sel_pll && !pll_level)
      s_next.sel_pll = 1'b1;
    s_next.clk = (s_next.sel_pin && pin_level) || (s_next.sel_pll && pll_level);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= '{sel_pin: 1'b1, sel_pll: 1'b0, clk: 1'b0};
    else
      s_reg <= s_next;
  end

  assign sys_clk = s_reg.clk;
  assign on_pin = s_reg.sel_pin;
  assign on_pll = s_reg.sel_pll;
endmodule

// [src/pcw_clock_ctrl.sv]
// Clock mode, PLL setting and wake-up control with an AXI4-Lite register port.
// Assumes the oscillator, VCO and wake sources sit outside and are synchronous to aclk.
`timescale 1ns/1ns
module pcw_clock_ctrl
  import pcw_pkg::*;
(
  input wire logic aclk, // Block clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [pcw_pkg::ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [pcw_pkg::ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic clock_input_pin, // Crystal or external clock level
  input wire logic pll_out_level, // PLL output level
  input wire logic [pcw_pkg::WAKE_SRCS-1:0] wake_in, // Wake-up sources
  output logic xtal_enable, // Crystal oscillator runs
  output logic vco_enable, // VCO runs
  output logic [pcw_pkg::MULT_W-1:0] vco_mult, // VCO frequency over PLL input
  output logic [pcw_pkg::MULT_W-1:0] pll_out_mult, // PLL output frequency over input
  output logic [1:0] pll_out_sel, // PLL output source select
  output logic sys_clk, // System clock level
  output logic core_restart // One-cycle restart from reset vector
);
  import pcw_pkg::*;

  typedef struct packed
  {
    pcw_state_t st;
    logic [15:0] ctrl;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wake_prev;
    logic restart;
    logic [MULT_W-1:0] vco_mult;
    logic [MULT_W-1:0] out_mult;
  } pcw_ctl_t;

  pcw_ctl_t s_reg;
  pcw_ctl_t s_next;
  pcw_mode_t mode;
  logic deep_bits;
  logic wake_now;
  logic on_pin;
  logic on_pll;
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] status_word;

  assign deep_bits = s_reg.ctrl[STOP_XTAL_BIT] && s_reg.ctrl[STOP_VCO_BIT]
    && s_reg.ctrl[SYS_SEL_BIT];
  // Level of the chosen wake input compared with the programmed polarity
  assign wake_now = (wake_in[s_reg.ctrl[WAKE_SRC_LSB +: 2]]
    == s_reg.ctrl[WAKE_POL_BIT]);

  always_comb
  begin
    case ({s_reg.ctrl[STOP_XTAL_BIT], s_reg.ctrl[STOP_VCO_BIT], s_reg.ctrl[SYS_SEL_BIT]})
      3'b000: mode = PCW_MODE_DEFAULT;
      3'b001: mode = PCW_MODE_PLL;
      3'b010: mode = PCW_MODE_XTAL_DIRECT;
      3'b110: mode = PCW_MODE_EXT_DIRECT;
      3'b111: mode = PCW_MODE_DEEP_SLEEP;
      default: mode = PCW_MODE_OTHER;
    endcase
  end

  assign status_word = {6'h00, s_reg.out_mult, 10'h000, on_pin, on_pll,
    (s_reg.st == PCW_ST_SLEEP), mode};

  // Writes are refused while a response waits, which keeps one write in flight
  assign awready = !s_reg.aw_got && !s_reg.bvalid;
  assign wready = !s_reg.w_got && !s_reg.bvalid;
  assign arready = !s_reg.rvalid;
  assign aw_have = s_reg.aw_got || (awvalid && awready);
  assign w_have = s_reg.w_got || (wvalid && wready);
  assign wr_addr = s_reg.aw_got ? s_reg.aw_addr : awaddr;
  assign wr_data = s_reg.w_got ? s_reg.w_data : wdata;
  assign wr_strb = s_reg.w_got ? s_reg.w_strb : wstrb;

  always_comb
  begin
    logic [7:0] div_l;
    logic [MULT_W-1:0] vco_l;
    div_l = s_reg.ctrl[DIV_LSB +: 8];
    vco_l = MULT_W'(VCO_MULT) * MULT_W'(div_l);
    s_next = s_reg;
    s_next.restart = 1'b0;
    s_next.wake_prev = wake_now;

    // Write channel
    if (awvalid && awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      s_next.w_got = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (aw_have && w_have)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      if (wr_addr == CTRL_OFFSET)
      begin
        s_next.bresp = RESP_OKAY;
        if (wr_strb[0])
          s_next.ctrl[7:0] = wr_data[7:0];
        if (wr_strb[1])
          s_next.ctrl[15:8] = wr_data[15:8];
      end
      else if (wr_addr == STAT_OFFSET)
        s_next.bresp = RESP_OKAY;
      else
        s_next.bresp = RESP_SLVERR;
    end
    else if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;

    // Read channel
    if (arvalid && arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      if (araddr == CTRL_OFFSET)
        s_next.rdata = {16'h0000, s_reg.ctrl};
      else if (araddr == STAT_OFFSET)
        s_next.rdata = status_word;
      else
      begin
        s_next.rdata = 32'h0000_0000;
        s_next.rresp = RESP_SLVERR;
      end
    end
    else if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;

    // Divisor outside 1..156 is not trapped; software keeps it in range
    s_next.vco_mult = vco_l;
    case (pcw_out_sel_t'(s_reg.ctrl[OUT_SEL_LSB +: 2]))
      PCW_OUT_VCO: s_next.out_mult = vco_l;
      PCW_OUT_VCO_DIV2: s_next.out_mult = {1'b0, vco_l[MULT_W-1:1]};
      PCW_OUT_VCO_DIV4: s_next.out_mult = {2'b00, vco_l[MULT_W-1:2]};
      PCW_OUT_XTAL_X2: s_next.out_mult = XTAL_X2_MULT;
      default: s_next.out_mult = vco_l;
    endcase

    case (s_reg.st)
      PCW_ST_RUN:
      begin
        if (deep_bits)
          s_next.st = PCW_ST_SLEEP;
      end
      PCW_ST_SLEEP:
      begin
        // A level already at the active polarity does not wake; only the change does
        if (wake_now && !s_reg.wake_prev)
        begin
          s_next.st = PCW_ST_RUN;
          s_next.restart = 1'b1;
          s_next.ctrl[SYS_SEL_BIT] = 1'b0;
          s_next.ctrl[STOP_VCO_BIT] = 1'b0;
          s_next.ctrl[STOP_XTAL_BIT] = 1'b0;
        end
      end
      default: s_next.st = PCW_ST_RUN;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.st <= PCW_ST_RUN;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.vco_mult <= MULT_W'(VCO_MULT);
      s_reg.out_mult <= MULT_W'(VCO_MULT);
    end
    else
      s_reg <= s_next;
  end

  // Settling time after starting the VCO is left to software; no hardware wait here
  pcw_clk_switch u_switch
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_level(clock_input_pin),
    .pll_level(pll_out_level),
    .want_pll(s_reg.ctrl[SYS_SEL_BIT]),
    .run(s_reg.st == PCW_ST_RUN),
    .sys_clk(sys_clk),
    .on_pin(on_pin),
    .on_pll(on_pll)
  );

  assign xtal_enable = !s_reg.ctrl[STOP_XTAL_BIT];
  assign vco_enable = !s_reg.ctrl[STOP_VCO_BIT];
  assign vco_mult = s_reg.vco_mult;
  assign pll_out_mult = s_reg.out_mult;
  assign pll_out_sel = s_reg.ctrl[OUT_SEL_LSB +: 2];
  assign core_restart = s_reg.restart;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
endmodule

// [tb/pcw_chk.sv]
// Port-level checker for the clock control block.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/1ns
module pcw_chk
  import pcw_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic awvalid, // Write address valid
  input wire logic awready, // Write address ready
  input wire logic wvalid, // Write data valid
  input wire logic wready, // Write data ready
  input wire logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic rvalid, // Read data valid
  input wire logic xtal_enable, // Crystal runs
  input wire logic vco_enable, // VCO runs
  input wire logic [pcw_pkg::MULT_W-1:0] vco_mult, // VCO ratio
  input wire logic [pcw_pkg::MULT_W-1:0] pll_out_mult, // Output ratio
  input wire logic [1:0] pll_out_sel, // Output select
  input wire logic core_restart // Restart pulse
);
  import pcw_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  chk_write_answer: assert property (s_wr_taken |=> bvalid && !awready)
    else $error("write not answered next cycle");
  chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read not answered next cycle");
  chk_resp_clears: assert property (bvalid && bready |=> !bvalid)
    else $error("write response held after accept");
  chk_vco_direct: assert property (
    pll_out_sel == 2'h0 && $past(pll_out_sel) == 2'h0 |-> pll_out_mult == vco_mult)
    else $error("output ratio differs from VCO ratio");
  chk_vco_half: assert property (
    pll_out_sel == 2'h1 && $past(pll_out_sel) == 2'h1 |-> pll_out_mult == vco_mult >> 1)
    else $error("output ratio not half the VCO");
  chk_vco_quarter: assert property (
    pll_out_sel == 2'h2 && $past(pll_out_sel) == 2'h2 |-> pll_out_mult == vco_mult >> 2)
    else $error("output ratio not a quarter of the VCO");
  chk_xtal_double: assert property (
    pll_out_sel == 2'h3 && $past(pll_out_sel) == 2'h3 |-> pll_out_mult == 10'h002)
    else $error("output ratio not twice the crystal");
  chk_restart_pulse: assert property (core_restart |=> !core_restart)
    else $error("restart pulse longer than one cycle");
  chk_wake_running: assert property (core_restart |-> xtal_enable && vco_enable)
    else $error("oscillators not running after wake");
  // A restart may only come out of sleep, where both oscillators were stopped
  chk_wake_source: assert property (
    core_restart |-> $past(xtal_enable) == 1'b0 && $past(vco_enable) == 1'b0)
    else $error("restart without a preceding sleep");
endmodule
bind pcw_clock_ctrl pcw_chk u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .xtal_enable(xtal_enable),
  .vco_enable(vco_enable), .vco_mult(vco_mult), .pll_out_mult(pll_out_mult),
  .pll_out_sel(pll_out_sel), .core_restart(core_restart));

// [tb/pcw_partner.sv]
// Crystal or external clock, VCO output and wake-up lines.
// Assumes the bench drives ext_clk and wake_set just after rising edges.
`timescale 1ns/1ns
module pcw_partner #(parameter int LOCK = 20)
(
  input wire logic aclk, // Clock
  input wire logic xtal_enable, // Crystal runs
  input wire logic vco_enable, // VCO runs
  input wire logic ext_clk, // External clock fitted
  input wire logic [3:0] wake_set, // Wake levels from bench
  output logic clock_input_pin, // Pin level
  output logic pll_out_level, // PLL level
  output logic [3:0] wake_in // Wake lines
);
  int ph = 0;
  int lock = 0;
  initial clock_input_pin = 1'b0;
  initial pll_out_level = 1'b0;
  assign wake_in = wake_set;
  always @(posedge aclk)
  begin
    ph <= ph + 1;
    // Settling shortened from the real figure to keep the run brief
    lock <= vco_enable ? lock + int'(lock < LOCK) : 0;
    // A stopped crystal leaves the pin flat unless a user clock drives it
    clock_input_pin <= (xtal_enable || ext_clk) ? ph[1] : 1'b0;
    pll_out_level <= (lock == LOCK) ? ph[0] : 1'b0;
  end
endmodule

// [tb/tb_pcw_clock_ctrl.sv]
// Bench for the clock control block: register tests over AXI4-Lite.
// Assumes the partner model for the pin, PLL and wake lines.
`timescale 1ns/1ns
module tb_pcw_clock_ctrl;
  import pcw_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, ext_clk = 0, awready, wready, bvalid, arready, rvalid;
  logic xtal_enable, vco_enable, sys_clk, core_restart, clock_input_pin, pll_out_level;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf, wake_set = 0, wake_in;
  logic [31:0] wdata = 0, rdata, r;
  logic [1:0] bresp, rresp, pll_out_sel, s;
  logic [9:0] vco_mult, pll_out_mult;
  logic [7:0] dv [2] = '{8'h01, 8'h9c};
  int fail_count = 0, comparisons = 0;
  pcw_clock_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .clock_input_pin(clock_input_pin), .pll_out_level(pll_out_level), .wake_in(wake_in),
    .xtal_enable(xtal_enable), .vco_enable(vco_enable), .vco_mult(vco_mult),
    .pll_out_mult(pll_out_mult), .pll_out_sel(pll_out_sel), .sys_clk(sys_clk),
    .core_restart(core_restart));
  pcw_partner FAR (.aclk(aclk), .xtal_enable(xtal_enable), .vco_enable(vco_enable),
    .ext_clk(ext_clk), .wake_set(wake_set), .clock_input_pin(clock_input_pin),
    .pll_out_level(pll_out_level), .wake_in(wake_in));
  initial
  begin
    forever #50 aclk = ~aclk;
  end
  task automatic end_of_test();
    $display("counts: %0d compared, %0d mismatched", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ready is looked at on the falling edge so the release lands on the taking edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, td;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= {3{w}};
    {arvalid, rready} <= {2{!w}};
    for (int n = 0; n < 50; n++)
    begin
      @(negedge aclk);
      ta = w ? awvalid && awready : arvalid && arready;
      tw = wvalid && wready;
      td = w ? bvalid : rvalid;
      r = rdata;
      s = w ? bresp : rresp;
      @(posedge aclk);
      if (ta)
        {awvalid, arvalid} <= 2'b00;
      if (tw)
        wvalid <= 1'b0;
      if (td)
      begin
        {bready, rready} <= 2'b00;
        return;
      end
    end
    fail_count++;
    end_of_test();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] es);
    xfer(1'b1, a, d);
    chk("bresp", 32'(es), 32'(s));
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, e, input logic [1:0] es);
    xfer(1'b0, a, 32'h0);
    chk("rdata", e, r & m);
    chk("rresp", 32'(es), 32'(s));
  endtask
  // System clock must repeat the chosen source one cycle late
  task automatic follow(input logic use_pll);
    logic p;
    @(negedge aclk);
    p = use_pll ? pll_out_level : clock_input_pin;
    repeat (6)
    begin
      @(negedge aclk);
      chk("sys_clk", 32'(p), 32'(sys_clk));
      p = use_pll ? pll_out_level : clock_input_pin;
    end
  endtask
  task automatic watch(input int e);
    int c = 0;
    repeat (4)
    begin
      @(negedge aclk);
      c += int'(core_restart);
      if (e == 0)
        chk("sys_clk", 32'h0, 32'(sys_clk));
    end
    chk("restarts", e, c);
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFFSET, 32'hffffffff, 32'h0100, RESP_OKAY);
    rd(STAT_OFFSET, 32'h03ff003f, 32'h00040020, RESP_OKAY);
    rd(4'h8, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(4'hc, 32'h0000ff07, RESP_SLVERR);
    chk("enables", 32'h3, 32'({xtal_enable, vco_enable}));
    follow(1'b0);
    $display("test reset done");
    foreach (dv[i])
      for (int k = 0; k < 4; k++)
      begin
        wr(CTRL_OFFSET, {16'h0, dv[i], 3'h0, 2'(k), 3'h0}, RESP_OKAY);
        @(negedge aclk);
        chk("vco_mult", 32'(4 * dv[i]), 32'(vco_mult));
        chk("pll_out_sel", 32'(k), 32'(pll_out_sel));
        chk("pll_out_mult", (k == 3) ? 32'h2 : 32'(4 * dv[i]) >> k, 32'(pll_out_mult));
      end
    $display("test ratios done");
    ext_clk <= 1'b1;
    wr(CTRL_OFFSET, 32'h0106, RESP_OKAY);
    rd(STAT_OFFSET, 32'h7, 32'h3, RESP_OKAY);
    chk("enables", 32'h0, 32'({xtal_enable, vco_enable}));
    follow(1'b0);
    $display("test external clock done");
    wr(CTRL_OFFSET, 32'h0100, RESP_OKAY);
    repeat (30) @(posedge aclk);
    wr(CTRL_OFFSET, 32'h0101, RESP_OKAY);
    r = 32'h0;
    for (int n = 0; n < 20 && r[4] !== 1'b1; n++)
      xfer(1'b0, STAT_OFFSET, 32'h0);
    chk("status", 32'h11, r & 32'h37);
    follow(1'b1);
    $display("test pll clock done");
    wake_set <= 4'h4;
    wr(CTRL_OFFSET, 32'h01c7, RESP_OKAY);
    repeat (4) @(posedge aclk);
    rd(STAT_OFFSET, 32'hf, 32'hc, RESP_OKAY);
    chk("enables", 32'h0, 32'({xtal_enable, vco_enable}));
    watch(0);
    @(posedge aclk);
    wake_set <= 4'h5;
    watch(0);
    @(posedge aclk);
    wake_set <= 4'h1;
    watch(0);
    @(posedge aclk);
    wake_set <= 4'h5;
    watch(1);
    rd(CTRL_OFFSET, 32'hffffffff, 32'h01c0, RESP_OKAY);
    $display("test sleep done");
    end_of_test();
  end
endmodule
